// ### shared/cpl_pkg.sv
// package: command port constants, types and host command and pin structs
package cpl_pkg;
	// port-select pattern that routes the bus to the command path
	localparam logic [2:0]  SEL_COMMAND       = 3'h4;
	localparam logic [2:0]  SEL_IDLE          = 3'h0;
	// command byte fields
	localparam int          CMD_ADDR_BIT      = 7;
	localparam int          CMD_READ_BIT      = 6;
	localparam logic [7:0]  CMD_ADDR_FLAG     = 8'h80;
	localparam logic [7:0]  CMD_READ_FLAG     = 8'h40;
	localparam logic [7:0]  CMD_REG_MASK      = 8'h3f;
	localparam logic [7:0]  CMD_NIB_MASK      = 8'h0f;
	// register offsets of the device
	localparam logic [5:0]  REG_IFACE_CONFIG  = 6'h01;
	localparam logic [5:0]  REG_DESC_LOAD     = 6'h30;
	localparam logic [5:0]  REG_XADDR_LO      = 6'h3a;
	localparam logic [5:0]  REG_XADDR_HI      = 6'h3b;
	localparam logic [5:0]  REG_XDATA         = 6'h3c;
	localparam logic [15:0] REG_SPEED_OVERRIDE = 16'he6fb;
	localparam logic [7:0]  SPEED_FS_ONLY     = 8'h02;
	// descriptor storage and default-descriptor length
	localparam int          DESC_RAM_BYTES    = 500;
	localparam logic [15:0] DESC_DEFAULT_LEN  = 16'h0006;
	// strobe timing in ref clocks (40 ns each)
	localparam int          STROBE_NS         = 80;
	localparam int          CLK_NS            = 40;
	localparam int          STROBE_CYC        = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	// read strobe one cycle longer so synchronised data has settled at capture
	localparam int          READ_CYC          = STROBE_CYC + 1;

	// host command on the user side
	typedef struct packed {
		logic        read;   // read one register
		logic [5:0]  addr;
		logic [7:0]  data;
	} cpl_cmd_t;

	// pins driven toward the device
	typedef struct packed {
		logic [2:0]  sel;
		logic        cs_n;
		logic        wr_n;
		logic        rd_n;
		logic        oe_n;
	} cpl_pins_t;
endpackage : cpl_pkg

// ### hdl/cpl_sync.sv
// file: two-stage synchroniser for device pins
`timescale 1ns/1ps
module cpl_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         ref_clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_next;

	// first stage only feeds the second
	always_comb begin
		meta_next = d_in;
		sync_next = meta_reg;
	end

	// reset to the idle level of each pin, so no false edge follows reset
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign q_out = sync_reg;
endmodule : cpl_sync

// ### hdl/cpl_desc_mem.sv
// file: descriptor staging memory with registered read data
`timescale 1ns/1ps
module cpl_desc_mem #(
	parameter int DEPTH = 500,
	parameter int AW    = 9
) (
	input  wire logic          ref_clk_in,
	input  wire logic          wr_en_in,
	input  wire logic [AW-1:0] wr_addr_in,
	input  wire logic [7:0]    wr_data_in,
	input  wire logic [AW-1:0] rd_addr_in,
	output logic      [7:0]    rd_data_out
);
	logic [7:0] mem [DEPTH];
	logic [7:0] rd_data_reg;

	// synchronous write, registered read
	always_ff @(posedge ref_clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_reg <= mem[rd_addr_in];
	end

	assign rd_data_out = rd_data_reg;
endmodule : cpl_desc_mem

// ### hdl/cpl_host.sv
// file: host controller driving the command port and loading descriptors
`timescale 1ns/1ps
// Contract
// - select command path only with port-select pattern one-zero-zero
// - command bytes travel on the low eight data lines only
// - data byte carries one nibble in low bits, upper nibble first
// - multi-byte registers: each byte sent as its own nibble pair
// - begin command only while selected and ready is high
// - device drops ready per byte; send nothing while ready low
// - descriptor load: one address, length low byte first, then all bytes
// - descriptors ordered device, qualifier, high-speed, full-speed, strings
// - write 0x02 to 0xE6FB before download forces full-speed only
// - unindexed write: name target, then upper nibble, then lower nibble
// - length six selects default descriptor with three ids low byte first
module cpl_host #(
	parameter int DESC_DEPTH = cpl_pkg::DESC_RAM_BYTES,
	parameter int DESC_AW    = 9
) (
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_in,
	// user side: single register access
	input  wire logic                  cmd_valid_in,
	input  wire cpl_pkg::cpl_cmd_t     cmd_in,
	output logic                       cmd_ready_out,
	output logic                       rd_valid_out,
	output logic [7:0]                 rd_data_out,
	// user side: descriptor staging and load
	input  wire logic                  desc_wr_in,
	input  wire logic [DESC_AW-1:0]    desc_waddr_in,
	input  wire logic [7:0]            desc_wdata_in,
	input  wire logic [15:0]           desc_len_in,
	input  wire logic                  fs_only_in,
	input  wire logic                  load_start_in,
	output logic                       load_busy_out,
	output logic                       load_done_out,
	output logic                       int_seen_out,
	// device pins
	output cpl_pkg::cpl_pins_t         pins_out,
	output logic [7:0]                 bus_data_out,
	output logic                       bus_oe_out,
	input  wire logic [7:0]            bus_data_in,
	input  wire logic                  dev_ready_in,
	input  wire logic                  dev_int_n_in
);
	typedef enum {
		CPL_IDLE, CPL_WAIT_RDY, CPL_STROBE, CPL_HOLD, CPL_WAIT_INT, CPL_READ
	} cpl_state_t;
	typedef enum {
		CPL_L_IDLE, CPL_L_SPEED, CPL_L_ADDR, CPL_L_LEN_LO, CPL_L_LEN_HI,
		CPL_L_FETCH, CPL_L_DATA, CPL_L_DONE
	} cpl_lstate_t;

	// synchronised device inputs
	logic       ready_s;
	logic       int_n_s;
	logic [7:0] rdata_s;
	// ready and interrupt reset to their idle high level
	cpl_sync #(.W(10), .RST_VAL(10'h300)) u_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.d_in       ({dev_ready_in, dev_int_n_in, bus_data_in}),
		.q_out      ({ready_s, int_n_s, rdata_s})
	);

	// descriptor staging memory
	logic [DESC_AW-1:0] mem_raddr;
	logic [7:0]         mem_rdata;
	cpl_desc_mem #(.DEPTH(DESC_DEPTH), .AW(DESC_AW)) u_mem (
		.ref_clk_in  (ref_clk_in),
		.wr_en_in    (desc_wr_in),
		.wr_addr_in  (desc_waddr_in),
		.wr_data_in  (desc_wdata_in),
		.rd_addr_in  (mem_raddr),
		.rd_data_out (mem_rdata)
	);

	// byte engine state
	cpl_state_t         st_reg, st_next;
	logic [7:0]         byte_reg, byte_next;
	logic [1:0]         cnt_reg, cnt_next;
	cpl_pkg::cpl_pins_t pins_reg, pins_next;
	logic               oe_reg, oe_next;
	logic               rd_pend_reg, rd_pend_next;
	logic               rdv_reg, rdv_next;
	logic [7:0]         rdd_reg, rdd_next;
	logic               int_reg, int_next;
	// sequencer state
	cpl_lstate_t        ls_reg, ls_next;
	logic [7:0]         q_byte [6];
	logic [2:0]         q_len_reg, q_len_next;
	logic [2:0]         q_idx_reg, q_idx_next;
	logic [15:0]        dcnt_reg, dcnt_next;
	logic               busy_reg, busy_next;
	logic               done_reg, done_next;
	logic               crdy_reg, crdy_next;
	logic               ureq_reg, ureq_next;
	cpl_pkg::cpl_cmd_t  ucmd_reg, ucmd_next;
	logic [7:0]         seq_reg [6];
	logic [7:0]         seq_next [6];
	logic               byte_go;
	logic               byte_done;

	// queue holds the next up-to-six wire bytes
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			q_byte[i] = seq_reg[i];
		end
	end

	// wire-byte engine: wait ready, strobe, wait ready drop
	always_comb begin
		st_next      = st_reg;
		byte_next    = byte_reg;
		cnt_next     = cnt_reg;
		pins_next    = pins_reg;
		oe_next      = oe_reg;
		// a read keeps the interrupt masked until the line is seen idle again
		rd_pend_next = rd_pend_reg && !(int_n_s && st_reg != CPL_WAIT_INT
			&& st_reg != CPL_READ);
		rdv_next     = 1'b0;
		rdd_next     = rdd_reg;
		int_next     = int_reg | ~int_n_s;
		byte_done    = 1'b0;
		case (st_reg)
			CPL_IDLE: begin
				pins_next.cs_n = 1'b1;
				if (byte_go) begin
					byte_next      = q_byte[q_idx_reg];
					pins_next.sel  = cpl_pkg::SEL_COMMAND;
					pins_next.cs_n = 1'b0;
					st_next        = CPL_WAIT_RDY;
				end
			end
			CPL_WAIT_RDY: begin
				if (ready_s) begin
					oe_next       = 1'b1;
					pins_next.wr_n = 1'b0;
					cnt_next      = 2'(cpl_pkg::STROBE_CYC);
					st_next       = CPL_STROBE;
				end
			end
			CPL_STROBE: begin
				if (cnt_reg > 2'h1) begin
					cnt_next = cnt_reg - 2'h1;
				end else begin
					pins_next.wr_n = 1'b1;
					st_next        = CPL_HOLD;
				end
			end
			CPL_HOLD: begin
				oe_next = 1'b0;
				// ready may fall late; the sync delay covers it
				if (!ready_s) begin
					if (byte_reg[cpl_pkg::CMD_ADDR_BIT] && byte_reg[cpl_pkg::CMD_READ_BIT]) begin
						rd_pend_next = 1'b1;
						st_next      = CPL_WAIT_INT;
					end else begin
						byte_done = 1'b1;
						st_next   = CPL_IDLE;
					end
				end
			end
			CPL_WAIT_INT: begin
				// pending read owns the interrupt line
				if (!int_n_s) begin
					pins_next.rd_n = 1'b0;
					pins_next.oe_n = 1'b0;
					cnt_next       = 2'(cpl_pkg::READ_CYC); // covers sync delay
					st_next        = CPL_READ;
				end
			end
			CPL_READ: begin
				if (cnt_reg > 2'h1) begin
					cnt_next = cnt_reg - 2'h1;
				end else begin
					rdd_next       = rdata_s;
					rdv_next       = 1'b1;
					pins_next.rd_n = 1'b1;
					pins_next.oe_n = 1'b1;
					byte_done      = 1'b1;
					st_next        = CPL_IDLE;
				end
			end
			default: st_next = CPL_IDLE;
		endcase
		if (rd_pend_reg) begin
			int_next = int_reg; // read data, not an event
		end
	end

	// helpers that build command bytes
	function automatic logic [7:0] addr_byte(input logic rd, input logic [5:0] a);
		addr_byte = cpl_pkg::CMD_ADDR_FLAG | (rd ? cpl_pkg::CMD_READ_FLAG : 8'h00)
			| ({2'h0, a} & cpl_pkg::CMD_REG_MASK);
	endfunction : addr_byte
	function automatic logic [7:0] hi_nib(input logic [7:0] v);
		hi_nib = {4'h0, v[7:4]} & cpl_pkg::CMD_NIB_MASK;
	endfunction : hi_nib
	function automatic logic [7:0] lo_nib(input logic [7:0] v);
		lo_nib = v & cpl_pkg::CMD_NIB_MASK;
	endfunction : lo_nib

	// sequencer: builds byte groups and walks the descriptor load
	always_comb begin
		ls_next    = ls_reg;
		q_len_next = q_len_reg;
		q_idx_next = q_idx_reg;
		dcnt_next  = dcnt_reg;
		busy_next  = busy_reg;
		done_next  = 1'b0;
		crdy_next  = crdy_reg;
		ureq_next  = ureq_reg;
		ucmd_next  = ucmd_reg;
		mem_raddr  = DESC_AW'(dcnt_reg);
		for (int i = 0; i < 6; i++) begin
			seq_next[i] = seq_reg[i];
		end
		byte_go = (q_idx_reg < q_len_reg) && (st_reg == CPL_IDLE);
		if (byte_done) begin
			q_idx_next = q_idx_reg + 3'h1;
		end
		// a whole group goes out unbroken, so no partial write is left
		if (q_idx_next == q_len_reg && q_len_reg != 3'h0 && byte_done) begin
			q_len_next = 3'h0;
			q_idx_next = 3'h0;
		end
		case (ls_reg)
			CPL_L_IDLE: begin
				if (q_len_reg == 3'h0 && !byte_done) begin
					if (load_start_in) begin
						busy_next = 1'b1;
						crdy_next = 1'b0;
						ls_next   = fs_only_in ? CPL_L_SPEED : CPL_L_ADDR;
					end else if (ureq_reg) begin
						ureq_next   = 1'b0;
						seq_next[0] = addr_byte(ucmd_reg.read, ucmd_reg.addr);
						seq_next[1] = hi_nib(ucmd_reg.data);
						seq_next[2] = lo_nib(ucmd_reg.data);
						q_len_next  = ucmd_reg.read ? 3'h1 : 3'h3;
					end else if (cmd_valid_in && crdy_reg) begin
						ureq_next = 1'b1;
						ucmd_next = cmd_in;
						crdy_next = 1'b0;
					end else begin
						// ready only once every byte of the last command is out
						crdy_next = 1'b1;
					end
				end
			end
			CPL_L_SPEED: begin
				// unindexed: low address, high address, value
				if (q_len_reg == 3'h0 && !byte_done) begin
					seq_next[0] = addr_byte(1'b0, cpl_pkg::REG_XADDR_LO);
					seq_next[1] = hi_nib(cpl_pkg::REG_SPEED_OVERRIDE[7:0]);
					seq_next[2] = lo_nib(cpl_pkg::REG_SPEED_OVERRIDE[7:0]);
					seq_next[3] = addr_byte(1'b0, cpl_pkg::REG_XADDR_HI);
					seq_next[4] = hi_nib(cpl_pkg::REG_SPEED_OVERRIDE[15:8]);
					seq_next[5] = lo_nib(cpl_pkg::REG_SPEED_OVERRIDE[15:8]);
					q_len_next  = 3'h6;
					ls_next     = CPL_L_DATA;
					dcnt_next   = 16'hffff; // marks speed value pending
				end
			end
			CPL_L_ADDR: begin
				if (q_len_reg == 3'h0 && !byte_done) begin
					seq_next[0] = addr_byte(1'b0, cpl_pkg::REG_DESC_LOAD);
					seq_next[1] = hi_nib(desc_len_in[7:0]);
					seq_next[2] = lo_nib(desc_len_in[7:0]);
					seq_next[3] = hi_nib(desc_len_in[15:8]);
					seq_next[4] = lo_nib(desc_len_in[15:8]);
					q_len_next  = 3'h5;
					dcnt_next   = 16'h0000;
					ls_next     = CPL_L_FETCH;
				end
			end
			CPL_L_FETCH: begin
				// one cycle for the memory read register
				if (q_len_reg == 3'h0 && !byte_done) begin
					if (dcnt_reg >= desc_len_in) begin
						ls_next = CPL_L_DONE;
					end else begin
						ls_next = CPL_L_DATA;
					end
				end
			end
			CPL_L_DATA: begin
				if (q_len_reg == 3'h0 && !byte_done) begin
					if (dcnt_reg == 16'hffff) begin
						seq_next[0] = addr_byte(1'b0, cpl_pkg::REG_XDATA);
						seq_next[1] = hi_nib(cpl_pkg::SPEED_FS_ONLY);
						seq_next[2] = lo_nib(cpl_pkg::SPEED_FS_ONLY);
						q_len_next  = 3'h3;
						ls_next     = CPL_L_ADDR;
					end else begin
						// no address repeated between descriptor bytes
						seq_next[0] = hi_nib(mem_rdata);
						seq_next[1] = lo_nib(mem_rdata);
						q_len_next  = 3'h2;
						dcnt_next   = dcnt_reg + 16'h0001;
						ls_next     = CPL_L_FETCH;
					end
				end
			end
			CPL_L_DONE: begin
				busy_next = 1'b0;
				done_next = 1'b1; // signalled by interrupt later
				crdy_next = 1'b1;
				ls_next   = CPL_L_IDLE;
			end
			default: ls_next = CPL_L_IDLE;
		endcase
	end

	// register all state
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg      <= CPL_IDLE;
			byte_reg    <= 8'h00;
			cnt_reg     <= 2'h0;
			pins_reg    <= '{sel: cpl_pkg::SEL_IDLE, cs_n: 1'b1, wr_n: 1'b1,
				rd_n: 1'b1, oe_n: 1'b1};
			oe_reg      <= 1'b0;
			rd_pend_reg <= 1'b0;
			rdv_reg     <= 1'b0;
			rdd_reg     <= 8'h00;
			int_reg     <= 1'b0;
			ls_reg      <= CPL_L_IDLE;
			q_len_reg   <= 3'h0;
			q_idx_reg   <= 3'h0;
			dcnt_reg    <= 16'h0000;
			busy_reg    <= 1'b0;
			done_reg    <= 1'b0;
			crdy_reg    <= 1'b1;
			ureq_reg    <= 1'b0;
			ucmd_reg    <= '0;
			for (int i = 0; i < 6; i++) begin
				seq_reg[i] <= 8'h00;
			end
		end else begin
			st_reg      <= st_next;
			byte_reg    <= byte_next;
			cnt_reg     <= cnt_next;
			pins_reg    <= pins_next;
			oe_reg      <= oe_next;
			rd_pend_reg <= rd_pend_next;
			rdv_reg     <= rdv_next;
			rdd_reg     <= rdd_next;
			int_reg     <= int_next;
			ls_reg      <= ls_next;
			q_len_reg   <= q_len_next;
			q_idx_reg   <= q_idx_next;
			dcnt_reg    <= dcnt_next;
			busy_reg    <= busy_next;
			done_reg    <= done_next;
			crdy_reg    <= crdy_next;
			ureq_reg    <= ureq_next;
			ucmd_reg    <= ucmd_next;
			for (int i = 0; i < 6; i++) begin
				seq_reg[i] <= seq_next[i];
			end
		end
	end

	// outputs straight from flops
	assign cmd_ready_out = crdy_reg;
	assign rd_valid_out  = rdv_reg;
	assign rd_data_out   = rdd_reg;
	assign load_busy_out = busy_reg;
	assign load_done_out = done_reg;
	assign int_seen_out  = int_reg;
	assign pins_out      = pins_reg;
	assign bus_data_out  = byte_reg;
	assign bus_oe_out    = oe_reg;

	// strobe only while the command pattern is on the select lines
	AST_SEL_ON_STROBE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!pins_reg.wr_n |-> pins_reg.sel == cpl_pkg::SEL_COMMAND && !pins_reg.cs_n)
		else $error("write strobe without command select");
	// strobe starts only after ready was seen high
	AST_STROBE_AFTER_READY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(pins_reg.wr_n) |-> $past(ready_s))
		else $error("strobe started while ready low");
	// driving the bus never overlaps the device output enable
	AST_NO_CONTENTION: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!(oe_reg && !pins_reg.oe_n))
		else $error("bus contention");
	// strobe lasts the set width
	sequence s_strobe;
		!pins_reg.wr_n [*2];
	endsequence
	AST_STROBE_WIDTH: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(pins_reg.wr_n) |-> s_strobe ##1 pins_reg.wr_n)
		else $error("strobe width wrong");
	// length and descriptor groups: data bytes have bit seven clear; only slot zero may carry the address
	AST_DATA_BIT7: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(oe_reg && ls_reg == CPL_L_FETCH && q_idx_reg != 3'h0 && !pins_reg.wr_n)
		|-> !byte_reg[7])
		else $error("data byte with address flag");
	// read data captured only once a read is pending
	AST_READ_PAIR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		rdv_reg |-> $past(rd_pend_reg))
		else $error("read data without pending read");
	// data driven stays stable across the strobe
	AST_DATA_STABLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!pins_reg.wr_n |-> $stable(byte_reg) && oe_reg)
		else $error("data changed under strobe");
	// done pulse lasts one cycle and ends busy
	AST_DONE_PULSE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		done_reg |-> !busy_reg ##1 !done_reg)
		else $error("done pulse wrong");
endmodule : cpl_host

// ### tb/cpl_dev_model.sv
// device-side model of the command port, register file and descriptor loader
`timescale 1ns/1ps
module cpl_dev_model #(
	parameter int RDY_FAST = 3,
	parameter int RDY_SLOW = 9
) (
	input  wire logic               ref_clk_in,
	input  wire logic               rst_in,
	input  wire cpl_pkg::cpl_pins_t pins_in,
	input  wire logic [7:0]         bus_data_in,
	input  wire logic               bus_oe_in,
	input  wire logic               slow_in,
	output logic      [7:0]         bus_data_out,
	output logic                    ready_out,
	output logic                    int_n_out
);
	logic [7:0]  regs [64];
	logic [7:0]  desc [512];
	logic [15:0] xaddr;
	logic [15:0] dlen;
	logic [7:0]  speed_reg;
	logic [7:0]  rdata;
	logic [7:0]  b;
	logic [7:0]  v;
	logic [5:0]  addr;
	logic [3:0]  hi;
	logic        have_addr, have_hi, rd_pend, enum_pend, enum_done, pullup_on, wr_q, rd_q;
	int          dpos, busy, int_cnt, viol;
	wire logic   sel_ok = !pins_in.cs_n && pins_in.sel == cpl_pkg::SEL_COMMAND;

	// unselected bus shows the inverse, never a stale value
	assign bus_data_out = (sel_ok && !pins_in.oe_n) ? rdata : ~rdata;

	// byte engine: strobes sampled on the ref clock, blocking for readability
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_out <= 1'b1;
			int_n_out <= 1'b1;
			wr_q = 1'b1;
			rd_q = 1'b1;
			have_addr = 1'b0;
			have_hi = 1'b0;
			rd_pend = 1'b0;
			enum_pend = 1'b0;
			enum_done = 1'b0;
			pullup_on = 1'b1;
			speed_reg = 8'h00;
			rdata = 8'h00;
			busy = 0;
			int_cnt = 0;
			dpos = 0;
			viol = 0;
		end else begin
			// ready returns; a pending read then claims the interrupt line
			if (busy > 0) begin
				busy--;
				if (busy == 0) begin
					ready_out <= 1'b1;
					if (rd_pend)
						int_n_out <= 1'b0;
				end
			end
			// enumeration event held back while a read owns the line
			if (int_cnt > 0) begin
				int_cnt--;
				if (int_cnt == 0)
					int_n_out <= 1'b1;
			end else if (enum_pend && !rd_pend && busy == 0) begin
				pullup_on = 1'b1;
				enum_pend = 1'b0;
				enum_done = 1'b1;
				int_cnt = 8;
				int_n_out <= 1'b0;
			end
			// end of a read strobe completes the read
			if (sel_ok && pins_in.rd_n && !rd_q) begin
				if (bus_oe_in || !rd_pend)
					viol++;
				rd_pend = 1'b0;
				int_n_out <= 1'b1;
			end
			// byte taken at the deasserting edge of the write strobe
			if (sel_ok && pins_in.wr_n && !wr_q) begin
				b = bus_data_in;
				if (!ready_out || !bus_oe_in || rd_pend)
					viol++;
				else if (b[7]) begin
					if (have_addr && have_hi)
						viol++;
					addr = b[5:0];
					have_addr = !b[6];
					have_hi = 1'b0;
					dpos = 0;
					rd_pend = b[6];
					rdata = regs[b[5:0]];
				end else if (!have_addr)
					viol++;
				else if (!have_hi) begin
					hi = b[3:0];
					have_hi = 1'b1;
				end else begin
					v = {hi, b[3:0]};
					have_hi = 1'b0;
					regs[addr] = v;
					if (addr == cpl_pkg::REG_XADDR_LO)
						xaddr[7:0] = v;
					if (addr == cpl_pkg::REG_XADDR_HI)
						xaddr[15:8] = v;
					if (addr == cpl_pkg::REG_XDATA && xaddr == cpl_pkg::REG_SPEED_OVERRIDE)
						speed_reg = v;
					if (addr == cpl_pkg::REG_DESC_LOAD) begin
						if (dpos == 0)
							dlen[7:0] = v;
						else if (dpos == 1)
							dlen[15:8] = v;
						else
							desc[dpos-2] = v;
						dpos++;
						if (dpos > 2 && dpos == dlen + 2) begin
							pullup_on = 1'b0;
							enum_pend = 1'b1;
							enum_done = 1'b0;
						end
					end
				end
				ready_out <= 1'b0;
				busy = slow_in ? RDY_SLOW : RDY_FAST;
			end
			wr_q = pins_in.wr_n;
			rd_q = pins_in.rd_n;
		end
	end
endmodule : cpl_dev_model

// ### tb/command_port_descriptor_loader_bench.sv
// bench: register writes, reads and descriptor loads against the device model
`timescale 1ns/1ps
module command_port_descriptor_loader_bench;
	localparam logic [15:0] VEND_ID = 16'h1a2b; // arbitrary value
	localparam logic [15:0] PROD_ID = 16'h3c4d; // arbitrary value
	localparam logic [15:0] REL_ID  = 16'h0203; // arbitrary value
	logic               ref_clk_in, rst_in, cmd_valid_in, cmd_ready_out, rd_valid_out, slow;
	logic               desc_wr_in, fs_only_in, load_start_in, load_busy_out, load_done_out;
	logic               int_seen_out, bus_oe_out, dev_ready_in, dev_int_n_in;
	cpl_pkg::cpl_cmd_t  cmd_in;
	cpl_pkg::cpl_pins_t pins_out;
	logic [7:0]         rd_data_out, desc_wdata_in, bus_data_out, bus_data_in;
	logic [8:0]         desc_waddr_in;
	logic [15:0]        desc_len_in;
	logic [7:0]         img [16];
	logic [5:0]         t_addr [3];
	logic [7:0]         t_data [3];
	int                 n_fail, samples_checked;

	cpl_host i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
		.cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rd_valid_out(rd_valid_out),
		.rd_data_out(rd_data_out), .desc_wr_in(desc_wr_in), .desc_waddr_in(desc_waddr_in),
		.desc_wdata_in(desc_wdata_in), .desc_len_in(desc_len_in), .fs_only_in(fs_only_in),
		.load_start_in(load_start_in), .load_busy_out(load_busy_out),
		.load_done_out(load_done_out), .int_seen_out(int_seen_out), .pins_out(pins_out),
		.bus_data_out(bus_data_out), .bus_oe_out(bus_oe_out), .bus_data_in(bus_data_in),
		.dev_ready_in(dev_ready_in), .dev_int_n_in(dev_int_n_in));
	cpl_dev_model i_dev (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .pins_in(pins_out),
		.bus_data_in(bus_data_out), .bus_oe_in(bus_oe_out), .slow_in(slow),
		.bus_data_out(bus_data_in), .ready_out(dev_ready_in), .int_n_out(dev_int_n_in));

	// 25 MHz reference clock
	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// bounded wait at falling edges; a timeout shows up as a mismatch
	task automatic wait_for(ref logic s);
		int i;
		i = 0;
		while (s !== 1'b1 && i < 4000) begin
			@(negedge ref_clk_in);
			i++;
		end
		chk(16'(s), 16'h0001);
	endtask : wait_for

	task automatic send(input logic rd, input logic [5:0] a, input logic [7:0] d);
		wait_for(cmd_ready_out);
		cmd_in = '{read: rd, addr: a, data: d};
		cmd_valid_in = 1'b1;
		@(negedge ref_clk_in);
		cmd_valid_in = 1'b0;
	endtask : send

	// stage n bytes of img, start a load and check what the device received
	task automatic load(input int n, input logic fs);
		for (int i = 0; i < n; i++) begin
			desc_wr_in = 1'b1;
			desc_waddr_in = 9'(i);
			desc_wdata_in = img[i];
			@(negedge ref_clk_in);
		end
		desc_wr_in = 1'b0;
		desc_len_in = 16'(n);
		fs_only_in = fs;
		load_start_in = 1'b1;
		@(negedge ref_clk_in);
		load_start_in = 1'b0;
		chk(16'(load_busy_out), 16'h0001);
		wait_for(load_done_out);
		wait_for(i_dev.pullup_on);
		wait_for(int_seen_out);
		chk(i_dev.dlen, 16'(n));
		for (int i = 0; i < n; i++)
			chk(16'(i_dev.desc[i]), 16'(img[i]));
		chk(16'(i_dev.speed_reg), 16'(cpl_pkg::SPEED_FS_ONLY));
		chk(16'(i_dev.enum_done), 16'h0001);
	endtask : load

	// watchdog well beyond the expected run length
	initial begin
		#(40 * 60000);
		n_fail++;
		stop_test();
	end

	initial begin
		n_fail = 0;
		samples_checked = 0;
		rst_in = 1'b1;
		slow = 1'b0;
		cmd_valid_in = 1'b0;
		cmd_in = '0;
		desc_wr_in = 1'b0;
		desc_waddr_in = 9'h000;
		desc_wdata_in = 8'h00;
		desc_len_in = 16'h0000;
		fs_only_in = 1'b0;
		load_start_in = 1'b0;
		t_addr = '{cpl_pkg::REG_IFACE_CONFIG, 6'h3f, 6'h00};
		t_data = '{8'hb0, 8'h7f, 8'hff};
		repeat (8) @(negedge ref_clk_in);
		chk(16'(pins_out), 16'h000f);
		chk(16'(cmd_ready_out), 16'h0001);
		chk(16'(bus_oe_out), 16'h0000);
		rst_in = 1'b0;
		@(negedge ref_clk_in);
		// write then read back, boundary addresses, slow device in the middle
		for (int i = 0; i < 3; i++) begin
			slow = (i == 1);
			send(1'b0, t_addr[i], t_data[i]);
			wait_for(cmd_ready_out);
			chk(16'(i_dev.regs[t_addr[i]]), 16'(t_data[i]));
			send(1'b1, t_addr[i], 8'h00);
			wait_for(rd_valid_out);
			chk(16'(rd_data_out), 16'(t_data[i]));
		end
		chk(16'(int_seen_out), 16'h0000);
		// full descriptor load with full-speed forcing
		for (int i = 0; i < 10; i++)
			img[i] = 8'h5a ^ 8'(i * 7);
		load(10, 1'b1);
		// default descriptor: three ids, low byte first
		img[0] = VEND_ID[7:0];
		img[1] = VEND_ID[15:8];
		img[2] = PROD_ID[7:0];
		img[3] = PROD_ID[15:8];
		img[4] = REL_ID[7:0];
		img[5] = REL_ID[15:8];
		load(6, 1'b0);
		chk(16'(i_dev.viol), 16'h0000);
		stop_test();
	end
endmodule : command_port_descriptor_loader_bench
